// ==== rtl/i2c_seq_cfg.svh ====
`ifndef I2C_SEQ_CFG_SVH
`define I2C_SEQ_CFG_SVH

// ****************************************************************
// Timing
// ****************************************************************
// System clock period and nominal bus bit time, both in nanoseconds.
// The bit time is a fast-mode rate, which keeps a full frame short in cycles.
`define CLK_PERIOD_NS   5
`define BIT_TIME_NS     2500
// Each bit is split into four quarters; a quarter is the smallest bus step.
`define QTR_TIME_NS     (`BIT_TIME_NS / 4)
`define QTR_CYCLES      ((`QTR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DIV_W           10

// ****************************************************************
// Byte layout
// ****************************************************************
// Fixed top five bits of the first byte addressed to a 10-bit slave.
`define TENBIT_PREFIX   5'h1E
`define PREFIX_MSB      7
`define PREFIX_LSB      3
`define RW_BIT          0
`define BYTE_MSB        7
`define LAST_PHASE      2'h3
`define SAMPLE_PHASE    2'h2

`endif

// ==== rtl/i2c_seq_pkg.sv ====
package i2c_seq_pkg;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_TX     = 3'b010,
    ST_TXACK  = 3'b011,
    ST_RX     = 3'b100,
    ST_RXWAIT = 3'b101,
    ST_RXACK  = 3'b110,
    ST_HOLD   = 3'b111
  } seq_st_type;

  // ****************************************************************
  // Register state of the sequencer
  // ****************************************************************
  typedef struct packed {
    seq_st_type  st;
    logic        stopping;
    logic [1:0]  phase;
    logic [2:0]  bitcnt;
    logic [7:0]  shift;
    logic [7:0]  data;
    logic        data_full;
    logic [7:0]  rx_data;
    logic        rx_full;
    logic        start_p;
    logic        stop_p;
    logic        nack_flag;
    logic        ack_status;
    logic        ack_valid;
    logic        arb_lost;
    logic        is_read;
    logic        addr_phase;
    logic        in_frame;
    logic        ten_bit;
    logic        nak_q;
    logic        sda_oe;
    logic        scl_oe;
    logic        sda_m;
    logic        sda_s;
    logic        scl_m;
    logic        scl_s;
  } seq_state_type;

  // Quarter-bit divider state.
  typedef struct packed {
    logic [9:0] cnt;
    logic       tick;
  } div_state_type;

endpackage : i2c_seq_pkg

// ==== rtl/i2c_tick_divider.sv ====
`timescale 1ns/1ps
`include "i2c_seq_cfg.svh"

module i2c_tick_divider
  import i2c_seq_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control and enable output
  input  wire logic run,
  output logic      tick
);

  div_state_type s_q;
  div_state_type s_d;

  // ****************************************************************
  // Quarter-bit enable
  // ****************************************************************
  // Counter restarts while run is low, so the first quarter after enable is full length; it runs on freely in the idle state.
  always_comb
  begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!run)
    begin
      s_d.cnt = '0;
    end
    else if (s_q.cnt == `DIV_W'(`QTR_CYCLES - 1))
    begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + `DIV_W'(1);
    end
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : i2c_tick_divider

// ==== rtl/i2c_master_transfer_sequencer.sv ====
`timescale 1ns/1ps
`include "i2c_seq_cfg.svh"

module i2c_master_transfer_sequencer
  import i2c_seq_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       controller_enable,
  input  wire logic       tx_irq_enable,
  input  wire logic       start_set,
  input  wire logic       stop_set,
  input  wire logic       nak_ctl,
  input  wire logic       arb_clr,
  // Data path
  input  wire logic       tx_wr,
  input  wire logic [7:0] tx_data,
  input  wire logic       rx_rd,
  output logic      [7:0] rx_data,
  // Status
  output logic            tx_data_empty,
  output logic            rx_data_full,
  output logic            nack_irq_flag,
  output logic            ack_status,
  output logic            ack_valid,
  output logic            arb_lost,
  output logic            start_pending,
  output logic            stop_pending,
  output logic            busy,
  output logic            ten_bit_addr,
  output logic            irq,
  // Bus pins, open drain
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe
);

  seq_state_type s_q;
  seq_state_type s_d;
  logic          tick;
  logic          adv;
  logic          last;
  logic          sample;

  // ****************************************************************
  // Quarter-bit timing
  // ****************************************************************
  i2c_tick_divider u_div (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (controller_enable),
    .tick  (tick)
  );

  // The sample quarter stalls only while SCL is driven low here and reads low; a released SCL always advances.
  assign adv    = tick & ((s_q.phase != `SAMPLE_PHASE) | s_q.scl_s | ~s_q.scl_oe);
  assign last   = adv & (s_q.phase == `LAST_PHASE);
  assign sample = adv & (s_q.phase == `SAMPLE_PHASE);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Software clears come first, hardware next, software sets last so that
  // a set arriving with a clear is never lost.
  always_comb
  begin
    s_d       = s_q;
    s_d.sda_m = sda_in;
    s_d.scl_m = scl_in;
    s_d.sda_s = s_q.sda_m;
    s_d.scl_s = s_q.scl_m;
    if (rx_rd)
    begin
      s_d.rx_full = 1'b0;
    end
    if (arb_clr)
    begin
      s_d.arb_lost = 1'b0;
    end
    if (adv)
    begin
      s_d.phase = s_q.phase + 2'h1;
    end
    // Master addressing looks only at the byte itself, never at a mode setting.
    case (s_q.st)
      ST_IDLE:
      begin
        s_d.phase    = 2'h0;
        s_d.in_frame = 1'b0;
        if (!controller_enable)
        begin
          s_d.start_p = 1'b0;
          s_d.stop_p  = 1'b0;
        end
        else if (s_q.start_p && s_q.data_full)
        begin
          s_d.st = ST_START;
        end
        else if (s_q.stop_p)
        begin
          s_d.stop_p = 1'b0;
        end
      end
      ST_START:
      begin
        if (last)
        begin
          s_d.shift      = s_q.data;
          s_d.start_p    = 1'b0;
          s_d.ack_valid  = 1'b0;
          s_d.addr_phase = 1'b1;
          s_d.in_frame   = 1'b1;
          s_d.ten_bit    = (s_q.data[`PREFIX_MSB:`PREFIX_LSB] == `TENBIT_PREFIX);
          s_d.is_read    = s_q.data[`RW_BIT];
          s_d.bitcnt     = 3'h7;
          s_d.st         = ST_TX;
        end
      end
      ST_TX:
      begin
        if (sample && s_q.shift[`BYTE_MSB] && !s_q.sda_s)
        begin
          s_d.arb_lost = 1'b1;
          s_d.start_p  = 1'b0;
          s_d.phase    = 2'h0;
          s_d.st       = ST_IDLE;
        end
        else if (last)
        begin
          if (s_q.bitcnt == 3'h7)
          begin
            s_d.data_full = 1'b0;
          end
          s_d.shift  = {s_q.shift[6:0], 1'b0};
          s_d.bitcnt = s_q.bitcnt - 3'h1;
          if (s_q.bitcnt == 3'h0)
          begin
            s_d.st = ST_TXACK;
          end
        end
      end
      ST_TXACK:
      begin
        if (sample)
        begin
          s_d.ack_status = ~s_q.sda_s;
          s_d.ack_valid  = 1'b1;
        end
        if (last)
        begin
          s_d.addr_phase = 1'b0;
          s_d.bitcnt     = 3'h7;
          if (!s_q.ack_status)
          begin
            s_d.nack_flag = 1'b1;
            s_d.data_full = 1'b0;
            s_d.st        = ST_HOLD;
          end
          else if (s_q.addr_phase && s_q.is_read)
          begin
            s_d.st = ST_RX;
          end
          else
          begin
            s_d.st = ST_HOLD;
          end
        end
      end
      ST_RX:
      begin
        if (sample)
        begin
          s_d.shift = {s_q.shift[6:0], s_q.sda_s};
        end
        if (last)
        begin
          s_d.bitcnt = s_q.bitcnt - 3'h1;
          if (s_q.bitcnt == 3'h0)
          begin
            s_d.rx_data = s_q.shift;
            s_d.rx_full = 1'b1;
            s_d.st      = ST_RXWAIT;
          end
        end
      end
      ST_RXWAIT:
      begin
        // SCL stays low until the byte is read, giving software time to set NAK.
        s_d.phase = 2'h0;
        if (!s_q.rx_full)
        begin
          s_d.nak_q = nak_ctl;
          s_d.st    = ST_RXACK;
        end
      end
      ST_RXACK:
      begin
        if (last)
        begin
          s_d.bitcnt = 3'h7;
          if (s_q.nak_q)
          begin
            s_d.nack_flag = 1'b1;
            s_d.st        = ST_HOLD;
          end
          else
          begin
            s_d.st = ST_RX;
          end
        end
      end
      ST_HOLD:
      begin
        s_d.phase = 2'h0;
        if (s_q.stopping)
        begin
          if (last)
          begin
            s_d.stop_p    = 1'b0;
            s_d.nack_flag = 1'b0;
            s_d.stopping  = 1'b0;
            s_d.st        = ST_IDLE;
          end
          else
          begin
            s_d.phase = s_q.phase + {1'b0, adv};
          end
        end
        else if (s_q.stop_p || !controller_enable)
        begin
          s_d.stopping  = 1'b1;
          s_d.data_full = s_q.data_full & ~s_q.nack_flag;
        end
        else if (s_q.start_p && s_q.data_full)
        begin
          s_d.st = ST_START;
        end
        else if (!s_q.nack_flag && !s_q.is_read && s_q.data_full)
        begin
          s_d.shift  = s_q.data;
          s_d.bitcnt = 3'h7;
          s_d.st     = ST_TX;
        end
        // Otherwise the bus waits with SCL low.
      end
      default:
      begin
        s_d.st = ST_IDLE;
      end
    endcase
    // Software sets.
    if (tx_wr)
    begin
      s_d.data      = tx_data;
      s_d.data_full = 1'b1;
    end
    if (start_set)
    begin
      s_d.start_p = 1'b1;
    end
    if (stop_set)
    begin
      s_d.stop_p = 1'b1;
    end
    // Pin drive follows the next state so both enables leave flip-flops.
    case (s_d.st)
      ST_START:
      begin
        s_d.scl_oe = (s_d.in_frame && s_d.phase == 2'h0) || s_d.phase == 2'h3;
        s_d.sda_oe = s_d.phase[1];
      end
      ST_TX:
      begin
        s_d.scl_oe = ~s_d.phase[1];
        s_d.sda_oe = ~s_d.shift[`BYTE_MSB];
      end
      ST_TXACK, ST_RX:
      begin
        s_d.scl_oe = ~s_d.phase[1];
        s_d.sda_oe = 1'b0;
      end
      ST_RXACK:
      begin
        s_d.scl_oe = ~s_d.phase[1];
        s_d.sda_oe = ~s_d.nak_q;
      end
      ST_RXWAIT:
      begin
        s_d.scl_oe = 1'b1;
        s_d.sda_oe = 1'b0;
      end
      ST_HOLD:
      begin
        // Stop: SDA low under low SCL, raise SCL, then release SDA.
        s_d.scl_oe = ~(s_d.stopping && s_d.phase != 2'h0);
        s_d.sda_oe = ~(s_d.stopping && s_d.phase[1]);
      end
      default:
      begin
        s_d.scl_oe = 1'b0;
        s_d.sda_oe = 1'b0;
      end
    endcase
  end

  // State register; idle bus lines read high after reset.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q       <= '0;
      s_q.sda_m <= 1'b1;
      s_q.sda_s <= 1'b1;
      s_q.scl_m <= 1'b1;
      s_q.scl_s <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign tx_data_empty = ~s_q.data_full;
  assign irq           = controller_enable & ((tx_irq_enable & ~s_q.data_full)
                         | s_q.nack_flag | s_q.rx_full | s_q.arb_lost);
  assign rx_data       = s_q.rx_data;
  assign rx_data_full  = s_q.rx_full;
  assign nack_irq_flag = s_q.nack_flag;
  assign ack_status    = s_q.ack_status;
  assign ack_valid     = s_q.ack_valid;
  assign arb_lost      = s_q.arb_lost;
  assign start_pending = s_q.start_p;
  assign stop_pending  = s_q.stop_p;
  assign busy          = (s_q.st != ST_IDLE);
  assign ten_bit_addr  = s_q.ten_bit;
  assign sda_out       = 1'b0;
  assign sda_oe        = s_q.sda_oe;
  assign scl_out       = 1'b0;
  assign scl_oe        = s_q.scl_oe;

endmodule : i2c_master_transfer_sequencer

// ==== tb/i2c_seq_chk.sv ====
`timescale 1ns/1ps
`include "i2c_seq_cfg.svh"
// ************************************
// Sequencer port checker
// ************************************
module i2c_seq_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Software side
  input wire logic controller_enable,
  input wire logic tx_irq_enable,
  input wire logic tx_wr,
  input wire logic rx_rd,
  input wire logic tx_data_empty,
  input wire logic rx_data_full,
  input wire logic nack_irq_flag,
  input wire logic ack_status,
  input wire logic ack_valid,
  input wire logic arb_lost,
  input wire logic start_pending,
  input wire logic stop_pending,
  input wire logic busy,
  input wire logic irq,
  // Bus enables
  input wire logic sda_oe,
  input wire logic scl_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A refused byte is flagged one quarter after its acknowledge sample.
  localparam int NACK_LAG      = `QTR_CYCLES + 4;
  // The first bit takes four quarters after the start bit clears; one quarter is slack.
  localparam int FIRST_BIT_MAX = 5 * `QTR_CYCLES;
  logic        start_seen_q;
  logic [11:0] first_wait_q;
  // Counts cycles from the start bit clearing until the data register empties.
  // A counter stands in for a long delay range, which the tools would unroll.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      start_seen_q <= 1'b0;
      first_wait_q <= 12'h000;
    end
    else
    begin
      start_seen_q <= start_pending;
      if (start_seen_q && !start_pending && !arb_lost)
      begin
        first_wait_q <= 12'h001;
      end
      else if (first_wait_q != 12'h000 && !tx_data_empty && !arb_lost)
      begin
        first_wait_q <= first_wait_q + 12'h001;
      end
      else
      begin
        first_wait_q <= 12'h000;
      end
    end
  end
  sequence s_nack_flush;
    ##[1:NACK_LAG] (nack_irq_flag && tx_data_empty);
  endsequence
  property p_irq_sum;
    irq == (controller_enable && ((tx_irq_enable && tx_data_empty)
      || nack_irq_flag || rx_data_full || arb_lost));
  endproperty
  property p_stop_clears;
    $fell(busy) && !arb_lost |-> !stop_pending && !nack_irq_flag;
  endproperty
  empty_clear_a: assert property (tx_wr |=> !tx_data_empty)
    else $error("data register still empty after a write");
  irq_sum_a: assert property (p_irq_sum)
    else $error("irq disagrees with its causes");
  first_bit_a: assert property (first_wait_q <= 12'(FIRST_BIT_MAX))
    else $error("no transmit empty after the first bit");
  start_gate_a: assert property ($rose(busy) |-> start_pending && !tx_data_empty)
    else $error("frame began without a pending start and byte");
  nack_flags_a: assert property ($fell(ack_status) && ack_valid |-> s_nack_flush)
    else $error("refused byte did not flag and flush");
  ack_valid_a: assert property ($rose(ack_status) |-> ack_valid)
    else $error("acknowledge set without ack valid");
  stop_clears_a: assert property (p_stop_clears)
    else $error("stop left flags set");
  rx_hold_a: assert property (scl_oe && rx_data_full && !rx_rd && busy |=> scl_oe)
    else $error("clock released while a byte waits");
  arb_drop_a: assert property ($rose(arb_lost) |-> ##[0:2] (!sda_oe && !scl_oe && !busy))
    else $error("lines not released after lost arbitration");
endmodule : i2c_seq_chk

// ==== tb/i2c_slave_model.sv ====
`timescale 1ns/1ps
// ************************************
// Remote slave on the open-drain wires
// ************************************
module i2c_slave_model (
  input wire logic       scl,
  input wire logic       sda,
  input wire logic [3:0] nack_at,
  input wire logic [7:0] rd_byte,
  output logic           pull,
  output logic [7:0]     first_byte,
  output logic           last_ack
);
  logic [7:0] sh = 8'h00;
  int nbit = 0;
  int nbyte = 0;
  logic rd = 1'b0;
  logic act = 1'b0;
  initial pull = 1'b0;
  // Start and Stop both restart the frame count. The short wait lets a clock fall
  // launched in the same step settle, so a data change under it is no false Start.
  always @(sda)
  begin
    #1;
    if (scl === 1'b1)
    begin
      nbit = 0;
      nbyte = 0;
      rd = 1'b0;
      pull = 1'b0;
      act = (sda === 1'b0);
    end
  end
  // Bits are taken while the clock is high, MSB first; power-up edges are ignored.
  always @(posedge scl) if (act)
  begin
    nbit++;
    if (nbit <= 8) sh = {sh[6:0], sda};
    if (nbit == 8 && nbyte == 0) first_byte = sh;
    if (nbit == 9) last_ack = sda;
  end
  // The wire changes only while the clock is low.
  always @(negedge scl) if (act)
  begin
    if (nbit == 9)
    begin
      nbit = 0;
      if (nbyte == 0) rd = sh[0];
      nbyte++;
    end
    pull = 1'b0;
    if (nbit == 8 && !(rd && nbyte > 0)) pull = (nbyte != nack_at);
    else if (nbit < 8 && rd && nbyte > 0) pull = ~rd_byte[7-nbit];
  end
endmodule : i2c_slave_model

// ==== tb/i2c_master_transfer_sequencer_tb.sv ====
`timescale 1ns/1ps
// ************************************
// Sequencer testbench
// ************************************
module i2c_master_transfer_sequencer_tb;
  logic clk, rst_n, controller_enable, tx_irq_enable, start_set, stop_set, nak_ctl;
  logic arb_clr, tx_wr, rx_rd, tb_pull, pull, last_ack;
  logic [7:0] tx_data, rx_data, first_byte, rd_byte;
  logic [3:0] nack_at;
  logic tx_data_empty, rx_data_full, nack_irq_flag, ack_status, ack_valid, arb_lost;
  logic start_pending, stop_pending, busy, ten_bit_addr, irq, sda_out, sda_oe, scl_out, scl_oe;
  wire sda = ~(sda_oe | pull | tb_pull);
  wire scl = ~scl_oe;
  int num_errors = 0;
  int checked = 0;
  i2c_master_transfer_sequencer uut (.clk, .rst_n, .controller_enable, .tx_irq_enable,
    .start_set, .stop_set, .nak_ctl, .arb_clr, .tx_wr, .tx_data, .rx_rd, .rx_data,
    .tx_data_empty, .rx_data_full, .nack_irq_flag, .ack_status, .ack_valid, .arb_lost,
    .start_pending, .stop_pending, .busy, .ten_bit_addr, .irq, .sda_in(sda), .sda_out,
    .sda_oe, .scl_in(scl), .scl_out, .scl_oe);
  i2c_slave_model slave (.scl, .sda, .nack_at, .rd_byte, .pull, .first_byte, .last_ack);
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic close_out();
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  function automatic logic sig(input int k);
    case (k)
      0: return tx_data_empty;
      1: return ack_valid;
      2: return nack_irq_flag;
      3: return rx_data_full;
      4: return !busy;
      5: return arb_lost;
      default: return !start_pending;
    endcase
  endfunction : sig
  // A wait that runs out ends the run as a failure.
  task automatic wait_on(input int k, input int n);
    for (int i = 0; i < n && sig(k) !== 1'b1; i++) @(negedge clk);
    if (sig(k) !== 1'b1)
    begin
      num_errors++;
      close_out();
    end
  endtask : wait_on
  task automatic wr(input logic [7:0] d);
    tx_data = d;
    tx_wr = 1'b1;
    @(negedge clk) tx_wr = 1'b0;
  endtask : wr
  // One-cycle pulses of start, stop, read and arbitration clear.
  task automatic ctl(input logic [3:0] v);
    {start_set, stop_set, rx_rd, arb_clr} = v;
    @(negedge clk) {start_set, stop_set, rx_rd, arb_clr} = 4'h0;
  endtask : ctl
  task automatic t_reset();
    chk("empty", tx_data_empty, 8'h01);
    chk("irq", irq, 8'h01);
    tx_irq_enable = 1'b0;
    @(negedge clk) chk("irq off", irq, 8'h00);
    chk("empty off", tx_data_empty, 8'h01);
    tx_irq_enable = 1'b1;
    ctl(4'h8);
    repeat (1200) @(negedge clk);
    chk("start waits", busy, 8'h00);
  endtask : t_reset
  // Ten-bit write; the slave refuses the data byte while one more is queued.
  task automatic t_write10();
    nack_at = 4'h2;
    wr(8'hF4);
    ctl(4'h8);
    wait_on(0, 6000);
    chk("loaded", start_pending, 8'h00);
    wr(8'h5A);
    wait_on(1, 20000);
    chk("ack", ack_status, 8'h01);
    chk("first byte", first_byte, 8'hF4);
    chk("ten bit", ten_bit_addr, 8'h01);
    wait_on(0, 6000);
    wr(8'hC3);
    wait_on(0, 20000);
    wr(8'h11);
    wait_on(2, 22000);
    chk("nack ack", ack_status, 8'h00);
    chk("flushed", tx_data_empty, 8'h01);
    repeat (600) @(negedge clk);
    chk("halted", {busy, scl_oe}, 8'h03);
    ctl(4'h4);
    wait_on(4, 6000);
    chk("stop flags", {stop_pending, nack_irq_flag}, 8'h00);
  endtask : t_write10
  // Single-byte seven-bit read, refused by the master.
  task automatic t_read7();
    nack_at = 4'hF;
    rd_byte = 8'hA5;
    nak_ctl = 1'b1;
    wr(8'h93);
    ctl(4'h8);
    wait_on(3, 45000);
    chk("rx data", rx_data, 8'hA5);
    chk("rx irq", {irq, ack_status}, 8'h03);
    repeat (600) @(negedge clk);
    chk("rx hold", scl_oe, 8'h01);
    ctl(4'h2);
    wait_on(2, 6000);
    chk("nak wire", last_ack, 8'h01);
    chk("rx read", rx_data_full, 8'h00);
    nak_ctl = 1'b0;
    ctl(4'h4);
    wait_on(4, 6000);
    chk("read stop", nack_irq_flag, 8'h00);
  endtask : t_read7
  // Another driver pulls the line low under a transmitted one.
  task automatic t_arb();
    wr(8'hF0);
    ctl(4'h8);
    wait_on(6, 6000);
    tb_pull = 1'b1;
    wait_on(5, 4000);
    tb_pull = 1'b0;
    @(negedge clk) chk("released", {busy, sda_oe, scl_oe, start_pending}, 8'h00);
    chk("drive level", {sda_out, scl_out}, 8'h00);
    ctl(4'h1);
    chk("arb clear", arb_lost, 8'h00);
  endtask : t_arb
  initial
  begin
    {rst_n, start_set, stop_set, nak_ctl, arb_clr, tx_wr, rx_rd, tb_pull} = 8'h00;
    {controller_enable, tx_irq_enable} = 2'b11;
    tx_data = 8'h00;
    rd_byte = 8'h00;
    nack_at = 4'hF;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_write10();
    t_read7();
    t_arb();
    close_out();
  end
endmodule : i2c_master_transfer_sequencer_tb

bind i2c_master_transfer_sequencer i2c_seq_chk chk (.clk, .rst_n, .controller_enable,
  .tx_irq_enable, .tx_wr, .rx_rd, .tx_data_empty, .rx_data_full, .nack_irq_flag, .ack_status,
  .ack_valid, .arb_lost, .start_pending, .stop_pending, .busy, .irq, .sda_oe, .scl_oe);
